// ===== verilog/dch_dma_ctrl.sv
// DMA channel controller: cycle sequencing, bus hold window and strobe timeout.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module dch_dma_ctrl
	import dch_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	dch_if.ctrl link,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	output logic bus_req_out,
	input wire logic bus_grant_in,
	output logic bus_own_out,
	output logic done_irq_out
);
	dch_state_t state_reg;
	logic [3:0] ctrl_reg;
	logic [15:0] count_reg;
	logic active_reg;
	logic done_reg;
	logic fault_reg;
	logic fin_reg;
	logic mem_seen_reg;
	logic io_seen_reg;
	logic [7:0] win_reg;
	logic [1:0] setup_reg;
	logic [4:0] tick_reg;
	logic [3:0] to_reg;
	logic addr_stb_reg;
	logic data_stb_reg;
	logic grant_reg;
	logic rw_reg;
	logic fault_out_reg;
	logic mem_ok;
	logic io_ok;
	logic tick;
	logic fault_hit;
	logic cyc_done;
	logic last_one;

	// ****************************************************************
	// Cycle completion and timeout events
	// ****************************************************************
	always_comb
	begin
		mem_ok = mem_seen_reg | ~link.slave_ack_n;
		io_ok = io_seen_reg | ~link.io_data_ready_n;
		tick = (tick_reg == TICK_CYC - 5'h01);
		fault_hit = addr_stb_reg && tick && (to_reg == TO_LAST);
		cyc_done = (state_reg == S_CYCLE) && mem_ok && io_ok && !fault_hit;
		last_one = (count_reg == 16'h0001);
	end

	// ****************************************************************
	// Strobe timeout counter
	// ****************************************************************
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			tick_reg <= 5'h00;
			to_reg <= 4'h0;
			fault_out_reg <= 1'b0;
		end
		else if (!addr_stb_reg)
		begin
			tick_reg <= 5'h00;
			to_reg <= 4'h0;
			fault_out_reg <= 1'b0;
		end
		else
		begin
			tick_reg <= tick ? 5'h00 : tick_reg + 5'h01;
			if (tick)
				to_reg <= to_reg + 4'h1;
			if (fault_hit)
				fault_out_reg <= 1'b1;
		end
	end

	// ****************************************************************
	// Channel sequencer
	// ****************************************************************
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_reg <= S_IDLE;
			addr_stb_reg <= 1'b0;
			data_stb_reg <= 1'b0;
			grant_reg <= 1'b0;
			rw_reg <= 1'b1;
			bus_req_out <= 1'b0;
			bus_own_out <= 1'b0;
			mem_seen_reg <= 1'b0;
			io_seen_reg <= 1'b0;
			win_reg <= 8'h00;
			setup_reg <= 2'h0;
			fin_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				S_IDLE:
				begin
					rw_reg <= 1'b1;
					fin_reg <= 1'b0;
					if (active_reg && !link.chan_xfer_request_n)
					begin
						bus_req_out <= 1'b1;
						state_reg <= S_BUSREQ;
					end
				end
				S_BUSREQ:
				begin
					if (!active_reg)
					begin
						bus_req_out <= 1'b0;
						state_reg <= S_IDLE;
					end
					else if (bus_grant_in)
					begin
						bus_req_out <= 1'b0;
						bus_own_out <= 1'b1;
						rw_reg <= ~ctrl_reg[CTRL_DIR_IN];
						setup_reg <= 2'h0;
						state_reg <= S_SETUP;
					end
				end
				S_SETUP:
				begin
					setup_reg <= setup_reg + 2'h1;
					if (setup_reg == RW_SETUP_CYC - 2'h1)
					begin
						addr_stb_reg <= 1'b1;
						grant_reg <= 1'b1;
						data_stb_reg <= ~ctrl_reg[CTRL_DIR_IN];
						mem_seen_reg <= 1'b0;
						io_seen_reg <= 1'b0;
						state_reg <= S_CYCLE;
					end
				end
				S_CYCLE:
				begin
					if (!link.slave_ack_n)
						mem_seen_reg <= 1'b1;
					if (!link.io_data_ready_n)
					begin
						io_seen_reg <= 1'b1;
						data_stb_reg <= 1'b1;
					end
					if (fault_hit)
					begin
						addr_stb_reg <= 1'b0;
						data_stb_reg <= 1'b0;
						grant_reg <= 1'b0;
						state_reg <= S_RELEASE;
					end
					else if (cyc_done)
					begin
						addr_stb_reg <= 1'b0;
						data_stb_reg <= 1'b0;
						grant_reg <= 1'b0;
						win_reg <= 8'h00;
						if (last_one)
						begin
							fin_reg <= 1'b1;
							state_reg <= S_RELEASE;
						end
						else
							state_reg <= S_HOLD;
					end
				end
				S_HOLD:
				begin
					win_reg <= win_reg + 8'h01;
					if (!link.chan_xfer_request_n)
					begin
						setup_reg <= RW_SETUP_CYC - 2'h1;
						state_reg <= S_SETUP;
					end
					else if (win_reg == (ctrl_reg[CTRL_PRIO] ? WIN1_CYC : WIN0_CYC) - 8'h01)
						state_reg <= S_RELEASE;
				end
				S_RELEASE:
				begin
					bus_own_out <= 1'b0;
					state_reg <= S_IDLE;
				end
				default:
				begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Software registers and channel status
	// ****************************************************************
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			ctrl_reg <= 4'h0;
			count_reg <= 16'h0000;
			active_reg <= 1'b0;
			done_reg <= 1'b0;
			fault_reg <= 1'b0;
		end
		else
		begin
			if (reg_wr_in && reg_addr_in == REG_CTRL)
				ctrl_reg <= reg_wdata_in[3:0];
			if (cyc_done)
				count_reg <= count_reg - 16'h0001;
			else if (reg_wr_in && reg_addr_in == REG_COUNT && !active_reg)
				count_reg <= reg_wdata_in[15:0];
			if (fault_hit || (cyc_done && last_one))
				active_reg <= 1'b0;
			else if (reg_wr_in && reg_addr_in == REG_CTRL && reg_wdata_in[CTRL_ARM] && count_reg != 16'h0000)
				active_reg <= 1'b1;
			if (state_reg == S_RELEASE && fin_reg)
				done_reg <= 1'b1;
			else if (reg_wr_in && reg_addr_in == REG_STATUS && reg_wdata_in[ST_DONE])
				done_reg <= 1'b0;
			if (fault_hit)
				fault_reg <= 1'b1;
			else if (reg_wr_in && reg_addr_in == REG_STATUS && reg_wdata_in[ST_FAULT])
				fault_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			reg_rdata_out <= 32'h00000000;
		else if (reg_rd_in)
		begin
			case (reg_addr_in)
				REG_CTRL: reg_rdata_out <= {28'h0000000, ctrl_reg};
				REG_COUNT: reg_rdata_out <= {16'h0000, count_reg};
				REG_STATUS: reg_rdata_out <= {28'h0000000, bus_own_out, fault_reg, done_reg, active_reg};
				default: reg_rdata_out <= 32'h00000000;
			endcase
		end
		else
			reg_rdata_out <= 32'h00000000;
	end

	// ****************************************************************
	// Interrupt and link outputs
	// ****************************************************************
	assign done_irq_out = done_reg & ctrl_reg[CTRL_IRQ_EN];
	assign link.bus_addr_strobe_n = ~addr_stb_reg;
	assign link.bus_data_strobe_n = ~data_stb_reg;
	assign link.chan_grant_ack_n = ~grant_reg;
	assign link.bus_read_write_n = rw_reg;
	assign link.bus_fault_n = ~fault_out_reg;
	assign link.last_xfer_n = ~(grant_reg & last_one);
endmodule : dch_dma_ctrl
`default_nettype wire

// ===== inc/dch_pkg.sv
// Shared constants for the DMA channel controller and its I/O card end.
package dch_pkg;
	localparam int CLK_NS = 10;
	localparam int WIN0_NS = 65;
	localparam int WIN1_NS = 1600;
	localparam int RW_SETUP_NS = 15;
	localparam int TICK_NS = 250;
	localparam int STB_MAX_NS = 3500;
	localparam logic [7:0] WIN0_CYC = 8'(WIN0_NS / CLK_NS);
	localparam logic [7:0] WIN1_CYC = 8'(WIN1_NS / CLK_NS);
	localparam logic [1:0] RW_SETUP_CYC = 2'((RW_SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [4:0] TICK_CYC = 5'(TICK_NS / CLK_NS);
	localparam logic [3:0] TO_LAST = 4'hf;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_COUNT = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int CTRL_ARM = 0;
	localparam int CTRL_PRIO = 1;
	localparam int CTRL_DIR_IN = 2;
	localparam int CTRL_IRQ_EN = 3;
	localparam int ST_ACTIVE = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAULT = 2;
	localparam int ST_OWN = 3;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_BUSREQ = 3'b001,
		S_SETUP = 3'b010,
		S_CYCLE = 3'b011,
		S_HOLD = 3'b100,
		S_RELEASE = 3'b101
	} dch_state_t;
endpackage : dch_pkg

// ===== inc/dch_if.sv
// Backplane DMA handshake signals between controller and I/O card end.
`timescale 1ns/10ps
`default_nettype none
interface dch_if;
	logic chan_xfer_request_n;
	logic chan_grant_ack_n;
	logic io_data_ready_n;
	logic bus_addr_strobe_n;
	logic bus_data_strobe_n;
	logic slave_ack_n;
	logic bus_fault_n;
	logic bus_read_write_n;
	logic last_xfer_n;
	modport ctrl (
		input chan_xfer_request_n, io_data_ready_n, slave_ack_n,
		output chan_grant_ack_n, bus_addr_strobe_n, bus_data_strobe_n, bus_fault_n, bus_read_write_n, last_xfer_n
	);
	modport card (
		output chan_xfer_request_n, io_data_ready_n, slave_ack_n,
		input chan_grant_ack_n, bus_addr_strobe_n, bus_data_strobe_n, bus_fault_n, bus_read_write_n, last_xfer_n
	);
endinterface : dch_if
`default_nettype wire

// ===== verilog/dch_io_card.sv
// I/O card and memory responder end of the DMA handshake.
`timescale 1ns/10ps
`default_nettype none
module dch_io_card
	import dch_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	dch_if.card link,
	input wire logic user_req_in,
	input wire logic io_ready_in,
	input wire logic mem_ready_in,
	input wire logic clear_last_in,
	output logic xfer_seen_out,
	output logic last_seen_out
);
	logic req_reg;
	logic rdy_reg;
	logic ack_reg;
	logic grant_d_reg;
	logic grant;
	logic out_dir;

	always_comb
	begin
		grant = ~link.chan_grant_ack_n;
		out_dir = link.bus_read_write_n;
	end

	// ****************************************************************
	// Request, ready and last-transfer tracking
	// ****************************************************************
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			req_reg <= 1'b0;
			rdy_reg <= 1'b0;
			grant_d_reg <= 1'b0;
			xfer_seen_out <= 1'b0;
			last_seen_out <= 1'b0;
		end
		else
		begin
			grant_d_reg <= grant;
			xfer_seen_out <= grant_d_reg & ~grant;
			if (grant && !link.last_xfer_n)
				last_seen_out <= 1'b1;
			else if (clear_last_in)
				last_seen_out <= 1'b0;
			if (grant)
				req_reg <= 1'b0;
			else
				req_reg <= user_req_in & ~last_seen_out;
			if (!grant)
				rdy_reg <= 1'b0;
			else if (io_ready_in && (!out_dir || !link.slave_ack_n))
				rdy_reg <= 1'b1;
		end
	end

	// ****************************************************************
	// Memory slave acknowledge
	// ****************************************************************
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			ack_reg <= 1'b0;
		else if (link.bus_addr_strobe_n)
			ack_reg <= 1'b0;
		else if (mem_ready_in && !link.bus_data_strobe_n)
			ack_reg <= 1'b1;
	end

	assign link.chan_xfer_request_n = ~req_reg;
	assign link.io_data_ready_n = ~rdy_reg;
	assign link.slave_ack_n = ~ack_reg;
endmodule : dch_io_card
`default_nettype wire

// ===== verification/dch_sva.sv
// Concurrent checks on the handshake signals joining the controller and the card end.
`timescale 1ns/10ps
`default_nettype none
module dch_sva
(
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic chan_xfer_request_n,
	input wire logic chan_grant_ack_n,
	input wire logic io_data_ready_n,
	input wire logic bus_addr_strobe_n,
	input wire logic bus_data_strobe_n,
	input wire logic slave_ack_n,
	input wire logic bus_fault_n,
	input wire logic bus_read_write_n,
	input wire logic last_xfer_n
);
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (!reset_n_in);
	// ********
	// Strobe length
	// ********
	logic [9:0] low_cnt_reg;
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			low_cnt_reg <= 10'h000;
		else if (bus_addr_strobe_n)
			low_cnt_reg <= 10'h000;
		else if (low_cnt_reg != 10'h3ff)
			low_cnt_reg <= low_cnt_reg + 10'h001;
	end
	AST_ACK_WITH_STROBE: assert property ($fell(bus_addr_strobe_n) |-> $fell(chan_grant_ack_n))
		else $error("acknowledge did not fall with address strobe");
	AST_END_TOGETHER: assert property ($rose(bus_addr_strobe_n) |-> $rose(chan_grant_ack_n) && bus_data_strobe_n)
		else $error("strobes and acknowledge did not rise together");
	AST_END_NEEDS_READY: assert property ($rose(bus_addr_strobe_n) |->
		!bus_fault_n || (!$past(slave_ack_n) && !$past(io_data_ready_n)))
		else $error("cycle ended before both acknowledges");
	AST_PROMPT_END: assert property (!bus_addr_strobe_n && !slave_ack_n && !io_data_ready_n |=> bus_addr_strobe_n)
		else $error("address strobe held after both acknowledges");
	AST_INPUT_DATA_AFTER_READY: assert property ($fell(bus_data_strobe_n) && !bus_read_write_n |->
		!$past(io_data_ready_n))
		else $error("input data strobe before card ready");
	AST_FAULT_TIME: assert property ($fell(bus_fault_n) |-> low_cnt_reg >= 10'h17c && low_cnt_reg <= 10'h19a)
		else $error("bus fault at wrong strobe length");
	AST_STROBE_CAP: assert property (low_cnt_reg <= 10'h19a)
		else $error("address strobe low too long");
	AST_STROBE_CLEAN: assert property ($rose(bus_addr_strobe_n) && bus_fault_n |-> low_cnt_reg <= 10'h15e)
		else $error("completed cycle held address strobe beyond limit");
	AST_FAULT_ABORT: assert property ($fell(bus_fault_n) |-> ##[0:2] bus_addr_strobe_n)
		else $error("bus fault did not end the cycle");
	AST_LAST_WITH_ACK: assert property (!last_xfer_n |-> !chan_grant_ack_n)
		else $error("last transfer outside acknowledge");
	AST_RESET_IDLE: assert property ($rose(reset_n_in) |-> bus_fault_n && chan_grant_ack_n && last_xfer_n)
		else $error("link not idle after reset");
endmodule : dch_sva
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench driving both ends of the DMA handshake.
`timescale 1ns/10ps
`default_nettype none
module tb
	import dch_pkg::*;
;
	logic clk_sys_in = 1'h0;
	logic reset_n_in = 1'h0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic reg_wr_in = 1'h0, reg_rd_in = 1'h0, bus_grant_in = 1'h0, user_req_in = 1'h1;
	logic io_ready_in = 1'h1, mem_ready_in = 1'h1, clear_last_in = 1'h0;
	logic [31:0] reg_rdata_out;
	logic bus_req_out, bus_own_out, done_irq_out, xfer_seen_out, last_seen_out, own_q;
	int miscompares = 0, compares = 0, nx = 0, nown = 0;
	dch_if dch_if_i ();
	dch_dma_ctrl dch_dma_ctrl_i (.clk_sys_in, .reset_n_in, .link(dch_if_i), .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .bus_req_out, .bus_grant_in, .bus_own_out, .done_irq_out);
	dch_io_card dch_io_card_i (.clk_sys_in, .reset_n_in, .link(dch_if_i), .user_req_in, .io_ready_in,
		.mem_ready_in, .clear_last_in, .xfer_seen_out, .last_seen_out);
	dch_sva dch_sva_i (.clk_sys_in, .reset_n_in, .chan_xfer_request_n(dch_if_i.chan_xfer_request_n),
		.chan_grant_ack_n(dch_if_i.chan_grant_ack_n), .io_data_ready_n(dch_if_i.io_data_ready_n),
		.bus_addr_strobe_n(dch_if_i.bus_addr_strobe_n), .bus_data_strobe_n(dch_if_i.bus_data_strobe_n),
		.slave_ack_n(dch_if_i.slave_ack_n), .bus_fault_n(dch_if_i.bus_fault_n),
		.bus_read_write_n(dch_if_i.bus_read_write_n), .last_xfer_n(dch_if_i.last_xfer_n));
	// ********
	// Clock, arbiter and event counters
	// ********
	initial
	begin
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in)
	begin
		own_q <= bus_own_out;
		bus_grant_in <= bus_req_out;
		if (xfer_seen_out)
			nx <= nx + 1;
		if (bus_own_out && !own_q)
			nown <= nown + 1;
	end
	// ********
	// Tasks
	// ********
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("miscompares=%0d compares=%0d", miscompares, compares);
		if (miscompares == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'h1;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'h1;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'h0;
		#1 d = reg_rdata_out;
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(d, exp);
	endtask : rdc
	// A card that drops its request while acknowledged and comes back after gap cycles.
	task automatic run(input logic [15:0] cnt, input logic [31:0] ctrl, input int gap, input int exp_own);
		int b;
		int x;
		b = nown;
		x = nx;
		wr(REG_COUNT, {16'h0000, cnt});
		wr(REG_CTRL, ctrl);
		for (int i = 0; i < 4000 && done_irq_out !== 1'h1; i++)
		begin
			@(posedge clk_sys_in);
			if (!dch_if_i.chan_grant_ack_n && gap > 0 && nx - x + 1 < cnt)
			begin
				user_req_in <= 1'h0;
				repeat (gap) @(posedge clk_sys_in);
				user_req_in <= 1'h1;
			end
		end
		chk({31'h0, done_irq_out}, 32'h1);
		if (done_irq_out !== 1'h1)
			end_of_test();
		chk({31'h0, bus_own_out}, 32'h0);
		repeat (30) @(posedge clk_sys_in);
		chk(nx - x, {16'h0000, cnt});
		chk(nown - b, exp_own);
		rdc(REG_STATUS, 32'h2);
		chk({31'h0, last_seen_out}, 32'h1);
		wr(REG_STATUS, 32'h2);
		@(posedge clk_sys_in);
		chk({31'h0, done_irq_out}, 32'h0);
		clear_last_in <= 1'h1;
		@(posedge clk_sys_in);
		clear_last_in <= 1'h0;
	endtask : run
	task automatic s_fault();
		logic [31:0] d;
		io_ready_in <= 1'h0;
		wr(REG_COUNT, 32'h1);
		wr(REG_CTRL, 32'h1);
		for (int i = 0; i < 300 && d[2] !== 1'h1; i++)
			rd(REG_STATUS, d);
		// The read that first shows the fault may still see the bus owned.
		chk(d & 32'h5, 32'h4);
		rdc(REG_STATUS, 32'h4);
		wr(REG_STATUS, 32'h4);
	endtask : s_fault
	initial
	begin
		repeat (3) @(posedge clk_sys_in);
		reset_n_in <= 1'h1;
		rdc(REG_STATUS, 32'h0);
		rdc(REG_COUNT, 32'h0);
		rdc(8'h0c, 32'h0);
		wr(REG_CTRL, 32'h1);
		rdc(REG_STATUS, 32'h0);
		run(16'h0002, 32'h9, 0, 1);
		run(16'h0003, 32'hf, 100, 1);
		run(16'h0003, 32'h9, 20, 3);
		s_fault();
		end_of_test();
	end
endmodule : tb
`default_nettype wire
